// ===== verilog/adcpp_pkg.sv
// Purpose: shared constants and state types of the result post-processor
// Assumes: 16-bit register port, word addressed; 12-bit conversion results
// Notes:   four filters and four comparators share this map
package adcpp_pkg;
  localparam int NUM_INST = 4;
  localparam int NUM_CHAN = 26;
  localparam int DW       = 16;
  localparam int RW       = 12;
  localparam int CHW      = 5;
  localparam int ACCW     = 20;
  localparam int CNTW     = 8;
  localparam int NCOND    = 5;
  localparam int MHI_W    = 10;
  localparam int AW       = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register map, word addresses
  localparam logic [AW-1:0] A_CMP_BASE = 8'h00;
  localparam logic [AW-1:0] A_CMP_STEP = 8'h08;
  localparam logic [AW-1:0] A_CMP_CON  = 8'h00;
  localparam logic [AW-1:0] A_CMP_LO   = 8'h01;
  localparam logic [AW-1:0] A_CMP_HI   = 8'h02;
  localparam logic [AW-1:0] A_CMP_MLO  = 8'h03;
  localparam logic [AW-1:0] A_CMP_MHI  = 8'h04;
  localparam logic [AW-1:0] A_FLT_BASE = 8'h20;
  localparam logic [AW-1:0] A_FLT_STEP = 8'h02;
  localparam logic [AW-1:0] A_FLT_CON  = 8'h00;
  localparam logic [AW-1:0] A_FLT_DAT  = 8'h01;
  localparam logic [AW-1:0] A_IRQ_STAT = 8'h30;
  localparam logic [AW-1:0] A_IRQ_EN   = 8'h31;
  localparam logic [AW-1:0] A_IRQ_CLR  = 8'h32;

  ////////////////////////////////////////////////////////////////////////////
  // filter control fields
  localparam int F_EN    = 15;
  localparam int F_MODE  = 13;
  localparam int F_RATIO = 10;
  localparam int F_IE    = 9;
  localparam int F_RDY   = 8;
  localparam int F_SEL   = 0;
  localparam logic [1:0] MODE_AVG   = 2'h3;
  localparam logic [2:0] RATIO_HALF = 3'h4;

  // comparator control fields
  localparam int C_CHN  = 8;
  localparam int C_EN   = 7;
  localparam int C_IE   = 6;
  localparam int C_STAT = 5;
  localparam int C_BETWEEN_LIMITS_EVENT = 4;
  localparam int C_ABOVE_HIGH_EVENT = 3;
  localparam int C_BELOW_HIGH_EVENT = 2;
  localparam int C_ABOVE_LOW_EVENT = 1;
  localparam int C_BELOW_LOW_EVENT = 0;
  localparam logic [CHW-1:0] CH_LAST = 5'h19;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic             en;
    logic [1:0]       mode;
    logic [2:0]       ratio;
    logic             ie;
    logic             rdy;
    logic [CHW-1:0]   sel;
    logic [ACCW-1:0]  acc;
    logic [CNTW-1:0]  cnt;
    logic [DW-1:0]    dat;
  } adcpp_flt_t;

  typedef struct packed {
    adcpp_flt_t [NUM_INST-1:0]  f;
    logic [2*NUM_INST-1:0]      stat;
    logic [2*NUM_INST-1:0]      ien;
    logic [DW-1:0]              rdata;
  } adcpp_top_t;

  typedef struct packed {
    logic                en;
    logic                ie;
    logic                stat;
    logic [NCOND-1:0]    cond;
    logic [CHW-1:0]      chn;
    logic [DW-1:0]       lo;
    logic [DW-1:0]       hi;
    logic [NUM_CHAN-1:0] mask;
    logic                evt;
  } adcpp_cmp_t;
endpackage : adcpp_pkg

// ===== verilog/adcpp_cmp_if.sv
// Purpose: register strobes, result stream and readback of one comparator
// Assumes: driven by the post-processor top
// Notes:   evt is a one-cycle pulse per detected event
interface adcpp_cmp_if;
  import adcpp_pkg::*;
  logic            wr_con;
  logic            wr_lo;
  logic            wr_hi;
  logic            wr_mlo;
  logic            wr_mhi;
  logic            rd_con;
  logic [DW-1:0]   wdata;
  logic            res_valid;
  logic [CHW-1:0]  res_chan;
  logic [RW-1:0]   res_data;
  logic [DW-1:0]   con;
  logic [DW-1:0]   lo;
  logic [DW-1:0]   hi;
  logic [DW-1:0]   mlo;
  logic [DW-1:0]   mhi;
  logic            evt;
  modport host (output wr_con, wr_lo, wr_hi, wr_mlo, wr_mhi, rd_con, wdata,
                res_valid, res_chan, res_data,
                input con, lo, hi, mlo, mhi, evt);
  modport cmp  (input wr_con, wr_lo, wr_hi, wr_mlo, wr_mhi, rd_con, wdata,
                res_valid, res_chan, res_data,
                output con, lo, hi, mlo, mhi, evt);
endinterface : adcpp_cmp_if

// ===== verilog/adcpp_cmp.sv
// Purpose: one digital comparator over the per-channel result stream
// Assumes: at most one result per cycle
// Notes:   limits compare against the zero-extended 12-bit result
module adcpp_cmp
  import adcpp_pkg::*;
(
  input wire logic  clock,
  input wire logic  srst,
  adcpp_cmp_if.cmp  bus
);
  adcpp_cmp_t     s_reg;
  adcpp_cmp_t     s_next;
  logic [DW-1:0]  d;
  logic           sel_ok;
  logic           hit;

  assign d      = DW'(bus.res_data);
  // channels past the last have no mask bit and are never compared
  assign sel_ok = s_reg.en && bus.res_valid && bus.res_chan <= CH_LAST
                  && s_reg.mask[bus.res_chan];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next     = s_reg;
    s_next.evt = 1'b0;
    hit        = 1'b0;
    if (bus.wr_con) begin
      s_next.en   = bus.wdata[C_EN];
      s_next.ie   = bus.wdata[C_IE];
      s_next.cond = bus.wdata[C_BELOW_LOW_EVENT +: NCOND];
    end
    if (bus.wr_lo) begin
      s_next.lo = bus.wdata;
    end
    if (bus.wr_hi) begin
      s_next.hi = bus.wdata;
    end
    // RULE2 low mask half
    if (bus.wr_mlo) begin
      s_next.mask[DW-1:0] = bus.wdata;
    end
    // RULE3 ten stored bits
    if (bus.wr_mhi) begin
      s_next.mask[NUM_CHAN-1:DW] = bus.wdata[MHI_W-1:0];
    end
    // RULE12 read clears flag
    if (bus.rd_con) begin
      s_next.stat = 1'b0;
    end
    // RULE13 five conditions
    if (sel_ok) begin
      hit = (s_reg.cond[C_BETWEEN_LIMITS_EVENT] && d >= s_reg.lo && d < s_reg.hi)
         || (s_reg.cond[C_ABOVE_HIGH_EVENT] && d >= s_reg.hi)
         || (s_reg.cond[C_BELOW_HIGH_EVENT] && d <  s_reg.hi)
         || (s_reg.cond[C_ABOVE_LOW_EVENT] && d >= s_reg.lo)
         || (s_reg.cond[C_BELOW_LOW_EVENT] && d <  s_reg.lo);
    end
    // RULE12 capture channel, set wins
    if (hit) begin
      s_next.stat = 1'b1;
      s_next.chn  = bus.res_chan;
      s_next.evt  = 1'b1;
    end
    if (!s_next.en) begin
      s_next.stat = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus.con                = '0;
    bus.con[C_CHN +: CHW]  = s_reg.chn;
    bus.con[C_EN]          = s_reg.en;
    bus.con[C_IE]          = s_reg.ie;
    bus.con[C_STAT]        = s_reg.stat;
    bus.con[C_BELOW_LOW_EVENT +: NCOND] = s_reg.cond;
  end
  assign bus.lo  = s_reg.lo;
  assign bus.hi  = s_reg.hi;
  assign bus.mlo = s_reg.mask[DW-1:0];
  assign bus.mhi = DW'(s_reg.mask[NUM_CHAN-1:DW]);
  assign bus.evt = s_reg.evt;

  ////////////////////////////////////////////////////////////////////////////
  property p_capture;
    @(posedge clock) disable iff (srst)
    hit && !bus.wr_con |=> s_reg.stat && s_reg.chn == $past(bus.res_chan);
  endproperty
  a_capture: assert property (p_capture) else $error("event not captured"); // RULE12

  property p_below_low;
    @(posedge clock) disable iff (srst)
    sel_ok && s_reg.cond[C_BELOW_LOW_EVENT] && d < s_reg.lo |=> s_reg.evt;
  endproperty
  a_below_low: assert property (p_below_low) else $error("below-low missed"); // RULE13

  property p_masked;
    @(posedge clock) disable iff (srst)
    bus.res_valid && bus.res_chan <= CH_LAST && !s_reg.mask[bus.res_chan]
      |=> !s_reg.evt;
  endproperty
  a_masked: assert property (p_masked) else $error("masked channel compared"); // RULE2
endmodule : adcpp_cmp

// ===== verilog/adcpp_top.sv
// Purpose: four result filters and four digital comparators behind registers
// Assumes: one conversion result per cycle on res_*; registers word addressed
// Notes:   read data appear the cycle after the read strobe, zero otherwise
// What this block does
// RULE1 - four comparators and four filters, each with own registers, index 0-3
// RULE2 - 26-bit comparator mask, low register ch15-0, high register ch25-16
// RULE3 - high mask register reads zero above its ten stored bits
// RULE4 - enable bit runs filter; clearing it stops filter and clears ready
// RULE5 - mode 00 oversampling, 11 averaging; 01 and 10 reserved
// RULE6 - oversampling codes 0-3: 4,16,64,256 samples, one to four fraction bits
// RULE7 - oversampling codes 4-7: 2,8,32,128 samples, one to four fraction bits
// RULE8 - averaging: 12-bit result, codes 0-7 average 2 to 256 samples
// RULE9 - filter irq enable raises individual and common interrupt on ready; here both outputs also need the filter's A_IRQ_EN bit set
// RULE10 - ready set on new result, cleared when data register is read
// RULE11 - five-bit select: channels 0-23, 24 temperature, 25 band gap
// RULE12 - comparator event captures channel number and sets flag; read clears
// RULE13 - events below/above low, below/above high, and between limits
// RULE14 - accumulate selected channel to count, load scaled sum, set ready
// RULE15 - software changes mode, ratio, select only while filter disabled
//
// Implementation choices: the register offsets and the strobed register port.
module adcpp_top
  import adcpp_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 res_valid,
  input  wire logic [CHW-1:0]       res_chan,
  input  wire logic [RW-1:0]        res_data,
  input  wire logic [AW-1:0]        reg_addr,
  input  wire logic [DW-1:0]        reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [DW-1:0]        reg_rdata,
  output logic                      irq,
  output logic      [NUM_INST-1:0]  flt_irq
);
  adcpp_top_t                     s_reg;
  adcpp_top_t                     s_next;
  logic [NUM_INST-1:0]            flt_evt;
  logic [NUM_INST-1:0]            cmp_evt;
  logic [NUM_INST-1:0]            cmp_ie;
  logic [NUM_INST-1:0][DW-1:0]    cmp_con;
  logic [NUM_INST-1:0][DW-1:0]    cmp_lo;
  logic [NUM_INST-1:0][DW-1:0]    cmp_hi;
  logic [NUM_INST-1:0][DW-1:0]    cmp_mlo;
  logic [NUM_INST-1:0][DW-1:0]    cmp_mhi;

  function automatic logic [AW-1:0] cadr(input int i, input logic [AW-1:0] o);
    return AW'(A_CMP_BASE + AW'(i) * A_CMP_STEP + o);
  endfunction : cadr

  function automatic logic [AW-1:0] fadr(input int i, input logic [AW-1:0] o);
    return AW'(A_FLT_BASE + AW'(i) * A_FLT_STEP + o);
  endfunction : fadr

  // RULE5 RULE6 RULE7 RULE8 sample count
  function automatic logic [CNTW-1:0] flt_last(input logic [1:0] m,
                                              input logic [2:0] r);
    logic [3:0] lg;
    lg = 4'h0;
    if (m == MODE_AVG) begin
      lg = 4'(r) + 4'h1;
    end else if (r >= RATIO_HALF) begin
      lg = 4'((r - RATIO_HALF) << 1) + 4'h1;
    end else begin
      lg = 4'(r << 1) + 4'h2;
    end
    return CNTW'((9'h001 << lg) - 9'h001);
  endfunction : flt_last

  // RULE6 RULE7 RULE8 result scaling
  function automatic logic [3:0] flt_shift(input logic [1:0] m,
                                           input logic [2:0] r);
    if (m != MODE_AVG && r >= RATIO_HALF) begin
      return 4'(r - RATIO_HALF);
    end
    return 4'(r) + 4'h1;
  endfunction : flt_shift

  ////////////////////////////////////////////////////////////////////////////
  // RULE1 four comparator instances
  for (genvar i = 0; i < NUM_INST; i++) begin : g_cmp
    adcpp_cmp_if cif ();
    assign cif.wr_con    = reg_write && reg_addr == cadr(i, A_CMP_CON);
    assign cif.wr_lo     = reg_write && reg_addr == cadr(i, A_CMP_LO);
    assign cif.wr_hi     = reg_write && reg_addr == cadr(i, A_CMP_HI);
    assign cif.wr_mlo    = reg_write && reg_addr == cadr(i, A_CMP_MLO);
    assign cif.wr_mhi    = reg_write && reg_addr == cadr(i, A_CMP_MHI);
    assign cif.rd_con    = reg_read && reg_addr == cadr(i, A_CMP_CON);
    assign cif.wdata     = reg_wdata;
    assign cif.res_valid = res_valid;
    assign cif.res_chan  = res_chan;
    assign cif.res_data  = res_data;
    assign cmp_con[i]    = cif.con;
    assign cmp_lo[i]     = cif.lo;
    assign cmp_hi[i]     = cif.hi;
    assign cmp_mlo[i]    = cif.mlo;
    assign cmp_mhi[i]    = cif.mhi;
    assign cmp_evt[i]    = cif.evt;
    assign cmp_ie[i]     = cif.con[C_IE];
    adcpp_cmp u_cmp (
      .clock (clock),
      .srst  (srst),
      .bus   (cif.cmp)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [ACCW-1:0]        sum;
    logic [2*NUM_INST-1:0]  ev;
    logic [2*NUM_INST-1:0]  clr;
    sum     = '0;
    ev      = '0;
    clr     = '0;
    s_next  = s_reg;
    s_next.rdata = '0;
    flt_evt = '0;
    for (int i = 0; i < NUM_INST; i++) begin
      // RULE15 asks for reconfigure only while disabled; this write is taken while enabled too
      if (reg_write && reg_addr == fadr(i, A_FLT_CON)) begin
        s_next.f[i].en    = reg_wdata[F_EN];
        s_next.f[i].mode  = reg_wdata[F_MODE +: 2];
        s_next.f[i].ratio = reg_wdata[F_RATIO +: 3];
        s_next.f[i].ie    = reg_wdata[F_IE];
        s_next.f[i].sel   = reg_wdata[F_SEL +: CHW];
      end
      // RULE10 data read clears ready
      if (reg_read && reg_addr == fadr(i, A_FLT_DAT)) begin
        s_next.f[i].rdy = 1'b0;
      end
      // RULE11 RULE14 selected channel accumulates
      if (s_reg.f[i].en && s_next.f[i].en && res_valid
          && res_chan == s_reg.f[i].sel) begin
        sum = s_reg.f[i].acc + ACCW'(res_data);
        if (s_reg.f[i].cnt == flt_last(s_reg.f[i].mode, s_reg.f[i].ratio)) begin
          s_next.f[i].dat = DW'(sum >> flt_shift(s_reg.f[i].mode, s_reg.f[i].ratio));
          s_next.f[i].rdy = 1'b1;
          s_next.f[i].acc = '0;
          s_next.f[i].cnt = '0;
          flt_evt[i]      = 1'b1;
        end else begin
          s_next.f[i].acc = sum;
          s_next.f[i].cnt = s_reg.f[i].cnt + CNTW'(1);
        end
      end
      // RULE4 disable stops and clears ready
      if (!s_next.f[i].en) begin
        s_next.f[i].rdy = 1'b0;
        s_next.f[i].acc = '0;
        s_next.f[i].cnt = '0;
      end
      // RULE9 events gated by enable bits
      ev[i]            = flt_evt[i] && s_reg.f[i].ie;
      ev[NUM_INST + i] = cmp_evt[i] && cmp_ie[i];
    end
    // sticky status: write-one clears, a same-cycle event wins
    if (reg_write && reg_addr == A_IRQ_CLR) begin
      clr = reg_wdata[2*NUM_INST-1:0];
    end
    if (reg_write && reg_addr == A_IRQ_EN) begin
      s_next.ien = reg_wdata[2*NUM_INST-1:0];
    end
    s_next.stat = (s_reg.stat & ~clr) | ev;
    // read mux; unmapped and write-only words read zero
    if (reg_read) begin
      for (int i = 0; i < NUM_INST; i++) begin
        if (reg_addr == fadr(i, A_FLT_CON)) begin
          s_next.rdata[F_EN]             = s_reg.f[i].en;
          s_next.rdata[F_MODE +: 2]      = s_reg.f[i].mode;
          s_next.rdata[F_RATIO +: 3]     = s_reg.f[i].ratio;
          s_next.rdata[F_IE]             = s_reg.f[i].ie;
          s_next.rdata[F_RDY]            = s_reg.f[i].rdy;
          s_next.rdata[F_SEL +: CHW]     = s_reg.f[i].sel;
        end
        if (reg_addr == fadr(i, A_FLT_DAT)) begin
          s_next.rdata = s_reg.f[i].dat;
        end
        if (reg_addr == cadr(i, A_CMP_CON)) begin
          s_next.rdata = cmp_con[i];
        end
        if (reg_addr == cadr(i, A_CMP_LO)) begin
          s_next.rdata = cmp_lo[i];
        end
        if (reg_addr == cadr(i, A_CMP_HI)) begin
          s_next.rdata = cmp_hi[i];
        end
        if (reg_addr == cadr(i, A_CMP_MLO)) begin
          s_next.rdata = cmp_mlo[i];
        end
        if (reg_addr == cadr(i, A_CMP_MHI)) begin
          s_next.rdata = cmp_mhi[i];
        end
      end
      if (reg_addr == A_IRQ_STAT) begin
        s_next.rdata = DW'(s_reg.stat);
      end
      if (reg_addr == A_IRQ_EN) begin
        s_next.rdata = DW'(s_reg.ien);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = s_reg.rdata;
  // RULE9 individual and common interrupt
  assign flt_irq   = s_reg.stat[NUM_INST-1:0] & s_reg.ien[NUM_INST-1:0];
  assign irq       = |(s_reg.stat & s_reg.ien);

  ////////////////////////////////////////////////////////////////////////////
  property p_mhi_zero;
    @(posedge clock) disable iff (srst)
    reg_read && reg_addr == A_CMP_MHI |=> reg_rdata[DW-1:MHI_W] == '0;
  endproperty
  a_mhi_zero: assert property (p_mhi_zero) else $error("mask high upper bits set"); // RULE3

  property p_disable;
    @(posedge clock) disable iff (srst)
    reg_write && reg_addr == A_FLT_BASE && !reg_wdata[F_EN]
      |=> !s_reg.f[0].rdy && s_reg.f[0].cnt == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("disable left ready set"); // RULE4

  property p_rdy_clear;
    @(posedge clock) disable iff (srst)
    reg_read && reg_addr == fadr(0, A_FLT_DAT) && !flt_evt[0]
      |=> !s_reg.f[0].rdy ##1 !s_reg.f[0].rdy || $rose(s_reg.f[0].rdy);
  endproperty
  a_rdy_clear: assert property (p_rdy_clear) else $error("ready not cleared"); // RULE10

  property p_irq;
    @(posedge clock) disable iff (srst)
    flt_evt[0] && s_reg.f[0].ie && s_reg.ien[0] && !reg_write
      |=> flt_irq[0] && irq;
  endproperty
  a_irq: assert property (p_irq) else $error("filter interrupt missing"); // RULE9

  property p_other_chan;
    @(posedge clock) disable iff (srst)
    !(res_valid && res_chan == s_reg.f[0].sel) && !reg_write
      |=> $stable(s_reg.f[0].acc) && $stable(s_reg.f[0].cnt);
  endproperty
  a_other_chan: assert property (p_other_chan) else $error("wrong channel taken"); // RULE11

  property p_ready_set;
    @(posedge clock) disable iff (srst)
    flt_evt[0] |=> s_reg.f[0].rdy && s_reg.f[0].acc == '0;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("result not loaded"); // RULE14
endmodule : adcpp_top

// ===== verif/adcpp_src_model.sv
// Purpose: conversion core stand-in feeding per-channel results
// Assumes: at most one result per cycle; a go pulse starts a burst
// Notes:   each real sample follows a decoy on the neighbour channel
module adcpp_src_model
  import adcpp_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            srst,
  input  wire logic            go,
  input  wire logic            slow,
  input  wire logic [CHW-1:0]  chan,
  input  wire logic [RW-1:0]   data,
  input  wire logic [8:0]      count,
  output logic                 busy,
  output logic                 res_valid,
  output logic      [CHW-1:0]  res_chan,
  output logic      [RW-1:0]   res_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0]     left_reg;
  logic [RW-1:0]  cur_reg;
  logic           real_reg;
  logic           gap_reg;
  assign busy = (left_reg != 9'h000);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (srst || go) begin
      left_reg  <= srst ? 9'h000 : count;
      cur_reg   <= data;
      real_reg  <= 1'b0;
      gap_reg   <= 1'b0;
      res_valid <= 1'b0;
      res_chan  <= 5'h00;
      res_data  <= 12'h000;
    end else if (busy && !gap_reg) begin
      res_valid <= 1'b1;
      res_chan  <= real_reg ? chan : chan ^ 5'h01;
      res_data  <= real_reg ? cur_reg : ~cur_reg;
      if (real_reg) begin
        left_reg <= left_reg - 9'h001;
        cur_reg  <= cur_reg + 12'h001;
        gap_reg  <= slow;
      end
      real_reg <= !real_reg;
    end else begin
      // idle lines toggle so stale values never look like data
      res_valid <= 1'b0;
      res_chan  <= ~res_chan;
      res_data  <= ~res_data;
      gap_reg   <= 1'b0;
    end
  end
endmodule : adcpp_src_model

// ===== verif/adc_result_postprocessor_test.sv
// Purpose: register-level test of the result post-processor
// Assumes: conversion results come from adcpp_src_model
// Notes:   expectations are computed here from the ratio tables
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

module adc_result_postprocessor_test
  import adcpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clock;
  logic                 srst;
  logic                 go;
  logic                 slow;
  logic                 busy;
  logic                 res_valid;
  logic                 reg_write;
  logic                 reg_read;
  logic                 irq;
  logic [CHW-1:0]       chan;
  logic [CHW-1:0]       res_chan;
  logic [RW-1:0]        data;
  logic [RW-1:0]        res_data;
  logic [8:0]           count;
  logic [AW-1:0]        reg_addr;
  logic [DW-1:0]        reg_wdata;
  logic [DW-1:0]        reg_rdata;
  logic [DW-1:0]        rv;
  logic [DW-1:0]        ex;
  logic [DW-1:0]        con;
  logic [NUM_INST-1:0]  flt_irq;
  logic [RW-1:0]        hit_val [5] = '{12'h080, 12'h100, 12'h1FF, 12'h200, 12'h100};
  logic [RW-1:0]        miss_val [5] = '{12'h100, 12'h0FF, 12'h200, 12'h1FF, 12'h200};
  int                   fails;
  int                   n_compared;
  int                   n;
  int                   sh;

  adcpp_top u_dut (.clock(clock), .srst(srst), .res_valid(res_valid), .res_chan(res_chan),
    .res_data(res_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .flt_irq(flt_irq));
  adcpp_src_model u_src (.clock(clock), .srst(srst), .go(go), .slow(slow), .chan(chan),
    .data(data), .count(count), .busy(busy), .res_valid(res_valid), .res_chan(res_chan),
    .res_data(res_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // bounded wait, then one edge so the last sample lands
  task automatic burst(input logic [CHW-1:0] c, input logic [RW-1:0] v, input int k);
    int t;
    t = 0;
    @(posedge clock);
    chan  <= c;
    data  <= v;
    count <= 9'(k);
    go    <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    #1;
    while (busy && t < 2000) begin
      @(posedge clock);
      #1;
      t++;
    end
    if (t == 2000) begin
      fails++;
      print_verdict();
    end
    @(posedge clock);
    #1;
  endtask : burst

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    {srst, go, slow, reg_write, reg_read} = 5'h10;
    {chan, data, count, reg_addr, reg_wdata} = '0;
    fails = 0;
    n_compared = 0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    #1;
    `CHK({irq, flt_irq}, 5'h00)
    for (int i = 0; i < 4; i++) begin
      logic [AW-1:0] cb;
      cb = A_CMP_BASE + A_CMP_STEP * 8'(i);
      rd(A_FLT_BASE + A_FLT_STEP * 8'(i), rv);
      `CHK(rv, 16'h0000)
      rd(cb + A_CMP_MHI, rv);
      `CHK(rv, 16'h0000)
      wr(cb + A_CMP_MLO, 16'hA5A0 | 16'(i));
      wr(cb + A_CMP_MHI, 16'hFFFF);
      rd(cb + A_CMP_MLO, rv);
      `CHK(rv, 16'hA5A0 | 16'(i))
      rd(cb + A_CMP_MHI, rv);
      `CHK(rv, 16'h03FF)
    end
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < 8; r++) begin
        if (m == 1) begin
          n = 2 << r;
          sh = r + 1;
        end else if (r < 4) begin
          n = 4 << (2 * r);
          sh = r + 1;
        end else begin
          n = 2 << (2 * (r - 4));
          sh = r - 4;
        end
        ex = 16'((n * 'h900 + n * (n - 1) / 2) >> sh);
        con = {1'b1, (m == 1) ? MODE_AVG : 2'h0, 3'(r), 10'h003};
        wr(A_FLT_BASE, 16'h0000);
        wr(A_FLT_BASE, con);
        slow <= (m == 1);
        burst(5'h03, 12'h900, n - 1);
        rd(A_FLT_BASE, rv);
        `CHK(rv, con)
        burst(5'h03, 12'h900 + 12'(n - 1), 1);
        rd(A_FLT_BASE, rv);
        `CHK(rv, con | 16'h0100)
        `CHK(flt_irq[0], 1'b0)
        rd(A_FLT_BASE + A_FLT_DAT, rv);
        `CHK(rv, ex)
        rd(A_FLT_BASE, rv);
        `CHK(rv, con)
      end
    end
    wr(A_IRQ_EN, 16'h00FF);
    wr(A_FLT_BASE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      logic [AW-1:0] fa;
      fa = A_FLT_BASE + A_FLT_STEP * 8'(i);
      con = {1'b1, 2'h0, RATIO_HALF, 1'b1, 1'b0, 3'h0, 5'h16 + 5'(i)};
      wr(fa, con);
      burst(5'h16 + 5'(i), 12'h321, 2);
      `CHK({irq, flt_irq}, {1'b1, 4'(1 << i)})
      rd(A_IRQ_STAT, rv);
      `CHK(rv, 16'(1 << i))
      rd(fa + A_FLT_DAT, rv);
      `CHK(rv, 16'h0643)
      wr(A_IRQ_CLR, 16'(1 << i));
      `CHK(irq, 1'b0)
      // off again so its select never catches the next decoys
      wr(fa, 16'h0000);
    end
    // masked source, then disable drops ready
    wr(A_IRQ_EN, 16'h0000);
    wr(A_FLT_BASE + 8'h06, con);
    burst(5'h19, 12'h321, 2);
    `CHK(irq, 1'b0)
    wr(A_IRQ_EN, 16'h0008);
    `CHK({irq, flt_irq}, 5'h18)
    wr(A_FLT_BASE + 8'h06, 16'h0000);
    rd(A_FLT_BASE + 8'h06, rv);
    `CHK(rv, 16'h0000)
    rd(A_IRQ_CLR, rv);
    `CHK(rv, 16'h0000)
    wr(8'h3F, 16'hFFFF);
    rd(8'h3F, rv);
    `CHK(rv, 16'h0000)
    wr(A_CMP_LO, 16'h0100);
    wr(A_CMP_HI, 16'h0200);
    wr(A_CMP_MLO, 16'h0020);
    wr(A_CMP_MHI, 16'h0200);
    for (int j = 0; j < 5; j++) begin
      con = 16'h0080 | 16'(1 << j);
      wr(A_CMP_CON, con);
      burst(5'h05, miss_val[j], 1);
      burst(5'h06, hit_val[j], 1);
      rd(A_CMP_CON, rv);
      `CHK(rv[5], 1'b0)
      burst(5'h05, hit_val[j], 1);
      rd(A_CMP_CON, rv);
      `CHK(rv, con | 16'h0520)
      rd(A_CMP_CON, rv);
      `CHK(rv[5], 1'b0)
    end
    wr(A_CMP_CON, 16'h0082);
    burst(5'h19, 12'h300, 1);
    rd(A_CMP_CON, rv);
    `CHK(rv, 16'h19A2)
    // comparator event reaches status and the common interrupt
    wr(A_IRQ_EN, 16'h0010);
    wr(A_CMP_CON, 16'h00C2);
    burst(5'h19, 12'h300, 1);
    rd(A_IRQ_STAT, rv);
    `CHK(rv, 16'h0018)
    `CHK({irq, flt_irq}, 5'h10)
    print_verdict();
  end
endmodule : adc_result_postprocessor_test
